//--- rtl/portable_address_decode_glue.sv
// Address separation, memory and I/O select decode, system output latch.
// Assumes CPU bus inputs are synchronous to clk; selects are registered.
`timescale 1ns/1ps
module portable_address_decode_glue
  import glue_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ale,
  input  wire logic [DATA_W-1:0] adIn,
  input  wire logic [7:0]        addrHigh,
  input  wire logic              readN,
  input  wire logic              writeN,
  input  wire logic              ioMemN,
  input  wire logic [DATA_W-1:0] keyReturn,
  output logic      [DATA_W-1:0] adOut,
  output logic                   adOe,
  output logic      [ADDR_W-1:0] addrOut,
  output logic                   romStdN,
  output logic                   romOptN,
  output logic      [NUM_RAM-1:0] ramSelN,
  output logic                   io_sel_ext_unit_n,
  output logic                   io_sel_line_relay_n,
  output logic                   io_sel_parallel_ctrl_n,
  output logic                   io_sel_serial_data_n,
  output logic                   io_sel_serial_mode_n,
  output logic                   io_sel_output_latch_n,
  output logic                   io_sel_display_n,
  output logic                   rom_bank_select,
  output logic                   printer_data_strobe,
  output logic                   clock_chip_strobe,
  output logic                   cassetteMotor
);
  bus_ctl_s          ctl;
  logic [DATA_W-1:0] lowAddr;
  logic [ADDR_W-1:0] fullAddr;
  logic              ioCycle;
  logic              memCycle;
  logic [NUM_IO-1:0] ioSelN;
  mem_sel_s          memSel;
  logic              latchWrite;
  logic              keyRead;

  logic [3:0]         systemLatch_reg;
  logic [ADDR_W-1:0]  addrOut_reg;
  mem_sel_s           memSel_reg;
  logic [NUM_IO-1:0]  ioSel_reg;
  logic [DATA_W-1:0]  adOut_reg;
  logic               adOe_reg;
  logic               latchWrite_d_reg;

  assign ctl.readN  = readN;
  assign ctl.writeN = writeN;
  assign ctl.ioMemN = ioMemN;

  low_address_latch u_low_address_latch (
    .clk     (clk),
    .rst     (rst),
    .ale     (ale),
    .adIn    (adIn),
    .lowAddr (lowAddr)
  );

  // In I/O cycles the CPU repeats the port number on the high byte
  assign fullAddr = {addrHigh, lowAddr};
  assign ioCycle  = ctl.ioMemN && !(ctl.readN && ctl.writeN);
  assign memCycle = !ctl.ioMemN && !(ctl.readN && ctl.writeN);

  io_page_decoder u_io_page_decoder (
    .ioCycle (ioCycle),
    .nibble  (fullAddr[IO_HI_BIT:IO_LO_BIT]),
    .selN    (ioSelN)
  );

  // Memory select decode
  always_comb begin
    memSel.romStdN = 1'b1;
    memSel.romOptN = 1'b1;
    memSel.ramN    = RAM_IDLE;
    if (memCycle) begin
      if (fullAddr[A15_BIT]) begin
        memSel.ramN[fullAddr[RAM_HI_BIT:RAM_LO_BIT]] = 1'b0;
      end else if (systemLatch_reg[LATCH_BANK_BIT]) begin
        memSel.romOptN = 1'b0;
      end else begin
        memSel.romStdN = 1'b0;
      end
    end
  end

  assign latchWrite = !ioSelN[IO_LATCH] && !ctl.writeN;
  assign keyRead    = !ioSelN[IO_LATCH] && !ctl.readN;

  // System output latch, captured once per write cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      systemLatch_reg  <= LATCH_RST;
      latchWrite_d_reg <= 1'b0;
    end else begin
      latchWrite_d_reg <= latchWrite;
      if (latchWrite && !latchWrite_d_reg) begin
        systemLatch_reg <= adIn[LATCH_MOTOR_BIT:LATCH_BANK_BIT];
      end
    end
  end

  // Registered address and selects
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrOut_reg <= '0;
      memSel_reg  <= {1'b1, 1'b1, RAM_IDLE};
      ioSel_reg   <= SEL_IDLE;
    end else begin
      addrOut_reg <= fullAddr;
      memSel_reg  <= memSel;
      ioSel_reg   <= ioSelN;
    end
  end

  // Keyboard return lines onto the data bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adOut_reg <= '0;
      adOe_reg  <= 1'b0;
    end else begin
      adOut_reg <= keyReturn;
      adOe_reg  <= keyRead;
    end
  end

  assign addrOut                = addrOut_reg;
  assign romStdN                = memSel_reg.romStdN;
  assign romOptN                = memSel_reg.romOptN;
  assign ramSelN                = memSel_reg.ramN;
  assign io_sel_ext_unit_n      = ioSel_reg[IO_EXT];
  assign io_sel_line_relay_n    = ioSel_reg[IO_RELAY];
  assign io_sel_parallel_ctrl_n = ioSel_reg[IO_PARALLEL];
  assign io_sel_serial_data_n   = ioSel_reg[IO_SERDATA];
  assign io_sel_serial_mode_n   = ioSel_reg[IO_SERMODE];
  assign io_sel_output_latch_n  = ioSel_reg[IO_LATCH];
  assign io_sel_display_n       = ioSel_reg[IO_DISPLAY];
  assign adOut                  = adOut_reg;
  assign adOe                   = adOe_reg;
  assign rom_bank_select        = systemLatch_reg[LATCH_BANK_BIT];
  assign printer_data_strobe    = systemLatch_reg[LATCH_PRINTER_DATA_STROBE_BIT];
  assign clock_chip_strobe      = systemLatch_reg[LATCH_CLK_BIT];
  assign cassetteMotor          = systemLatch_reg[LATCH_MOTOR_BIT];
endmodule : portable_address_decode_glue

//--- rtl/glue_pkg.sv
// Package: bus codes, address fields, latch bit positions, reset values.
// Assumes an 8-bit multiplexed CPU bus sampled on clk.
package glue_pkg;
  localparam int ADDR_W          = 16;
  localparam int DATA_W          = 8;
  localparam int A15_BIT         = 15;
  localparam int RAM_HI_BIT      = 14;
  localparam int RAM_LO_BIT      = 13;
  localparam int IO_HI_BIT       = 15;
  localparam int IO_LO_BIT       = 12;
  localparam int IO_HALF_BIT     = 15;
  localparam int NUM_RAM         = 4;
  localparam int NUM_IO          = 8;
  localparam int LATCH_BANK_BIT  = 0;
  localparam int LATCH_PRINTER_DATA_STROBE_BIT  = 1;
  localparam int LATCH_CLK_BIT   = 2;
  localparam int LATCH_MOTOR_BIT = 3;
  localparam logic [2:0] IO_EXT      = 3'h0;
  localparam logic [2:0] IO_RELAY    = 3'h1;
  localparam logic [2:0] IO_PARALLEL = 3'h3;
  localparam logic [2:0] IO_SERDATA  = 3'h4;
  localparam logic [2:0] IO_SERMODE  = 3'h5;
  localparam logic [2:0] IO_LATCH    = 3'h6;
  localparam logic [2:0] IO_DISPLAY  = 3'h7;
  localparam logic [7:0] LOW_ADDR_RST = 8'h00;
  localparam logic [3:0] LATCH_RST    = 4'h0;
  localparam logic [7:0] SEL_IDLE     = 8'hFF;
  localparam logic [3:0] RAM_IDLE     = 4'hF;

  typedef struct packed {
    logic readN;
    logic writeN;
    logic ioMemN;
  } bus_ctl_s;

  typedef struct packed {
    logic romStdN;
    logic romOptN;
    logic [NUM_RAM-1:0] ramN;
  } mem_sel_s;
endpackage : glue_pkg

//--- rtl/low_address_latch.sv
// Captures the low address byte from the shared lines on the latch strobe.
// Assumes the strobe is synchronous to clk and high in the address phase.
`timescale 1ns/1ps
module low_address_latch
  import glue_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ale,
  input  wire logic [DATA_W-1:0] adIn,
  output logic      [DATA_W-1:0] lowAddr
);
  logic [DATA_W-1:0] lowAddr_reg;

  // Transparent while strobe high, holds after it falls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowAddr_reg <= LOW_ADDR_RST;
    end else if (ale) begin
      lowAddr_reg <= adIn;
    end
  end

  assign lowAddr = ale ? adIn : lowAddr_reg;
endmodule : low_address_latch

//--- rtl/io_page_decoder.sv
// Decodes the top address nibble into eight active-low I/O selects.
// Assumes the caller qualifies with an I/O cycle.
`timescale 1ns/1ps
module io_page_decoder
  import glue_pkg::*;
(
  input  wire logic        ioCycle,
  input  wire logic [3:0]  nibble,
  output logic [NUM_IO-1:0] selN
);
  always_comb begin
    selN = SEL_IDLE;
    if (ioCycle && nibble[3]) begin
      selN[nibble[2:0]] = 1'b0;
    end
  end
endmodule : io_page_decoder

//--- sim/glue_sva.sv
// Checker: select decode and output latch relations at the top ports.
// Assumes selects and addrOut are registered on the same clock edge.
`timescale 1ns/1ps
module glue_sva
  import glue_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                readN,
  input wire logic                writeN,
  input wire logic [ADDR_W-1:0]   addrOut,
  input wire logic                romStdN,
  input wire logic                romOptN,
  input wire logic [NUM_RAM-1:0]  ramSelN,
  input wire logic                io_sel_ext_unit_n,
  input wire logic                io_sel_line_relay_n,
  input wire logic                io_sel_output_latch_n,
  input wire logic                io_sel_display_n,
  input wire logic                rom_bank_select,
  input wire logic                cassetteMotor,
  input wire logic                adOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ram_pick_a: assert property (ramSelN != RAM_IDLE |->
    addrOut[15] && ramSelN == ~(4'h1 << addrOut[14:13])) else $error("ram select wrong");
  rom_std_a: assert property (!romStdN |->
    !addrOut[15] && !rom_bank_select && romOptN) else $error("standard rom select wrong");
  rom_opt_a: assert property (!romOptN |->
    !addrOut[15] && rom_bank_select) else $error("optional rom select wrong");
  ext_block_a: assert property (!io_sel_ext_unit_n |->
    addrOut[15:12] == 4'h8) else $error("external unit select wrong");
  relay_block_a: assert property (!io_sel_line_relay_n |->
    addrOut[15:12] == 4'h9) else $error("line relay select wrong");
  display_block_a: assert property (!io_sel_display_n |->
    addrOut[15:12] == 4'hF) else $error("display select wrong");
  latch_hold_a: assert property ($changed({rom_bank_select, cassetteMotor}) |->
    !io_sel_output_latch_n) else $error("latch changed without write");
  key_gate_a: assert property (adOe |->
    !io_sel_output_latch_n) else $error("bus driven outside key read");
  idle_bus_a: assert property ($past(readN && writeN) |->
    ramSelN == RAM_IDLE && romStdN && io_sel_display_n) else $error("select without strobe");
endmodule : glue_sva

bind portable_address_decode_glue glue_sva u_sva (.clk(clk), .rst(rst), .readN(readN),
  .writeN(writeN), .addrOut(addrOut), .romStdN(romStdN), .romOptN(romOptN),
  .ramSelN(ramSelN), .io_sel_ext_unit_n(io_sel_ext_unit_n), .adOe(adOe),
  .io_sel_line_relay_n(io_sel_line_relay_n),
  .io_sel_output_latch_n(io_sel_output_latch_n), .io_sel_display_n(io_sel_display_n),
  .rom_bank_select(rom_bank_select), .cassetteMotor(cassetteMotor));

//--- sim/cpu_bus_model.sv
// CPU model: drives the multiplexed bus in latch, strobe and release phases.
// Assumes one access at a time, called from the bench.
`timescale 1ns/1ps
module cpu_bus_model
  import glue_pkg::*;
(
  input  wire logic        clk,
  output logic             ale,
  output logic [7:0]       adIn,
  output logic [7:0]       addrHigh,
  output bus_ctl_s         ctl
);
  initial begin
    ale = 1'b0;
    adIn = 8'h00;
    addrHigh = 8'h00;
    ctl = 3'h6;
  end
  task automatic access(input logic io, input logic wr, input logic [15:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    ale <= 1'b1;
    {addrHigh, adIn} <= a;
    @(posedge clk);
    ale <= 1'b0;
    adIn <= d;
    ctl <= {wr, ~wr, io};
    repeat (2) @(posedge clk);
    #1;
  endtask : access
  // Strobes drop, released lines show the inverse of the last byte
  task automatic idle();
    @(posedge clk);
    ctl <= {2'h3, ctl.ioMemN};
    adIn <= ~adIn;
  endtask : idle
endmodule : cpu_bus_model

//--- sim/tb.sv
// Testbench: bus accesses through the CPU model, checks at the ports.
// Assumes the model tasks return with selects settled.
`timescale 1ns/1ps
module tb;
  import glue_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ale, adOe, romStdN, romOptN;
  logic [7:0] adIn, addrHigh, adOut;
  logic [7:0] keyReturn = 8'h5A;
  logic [15:0] addrOut;
  logic [3:0] ramSelN;
  wire logic [3:0] lat;
  wire logic [6:0] sel;
  bus_ctl_s ctl;
  int miscompares = 0, samples_checked = 0, cycles = 0, k;
  always #25 clk = ~clk;
  cpu_bus_model cpu (.clk(clk), .ale(ale), .adIn(adIn), .addrHigh(addrHigh), .ctl(ctl));
  portable_address_decode_glue dut (.clk(clk), .rst(rst), .ale(ale), .adIn(adIn),
    .addrHigh(addrHigh), .readN(ctl.readN), .writeN(ctl.writeN), .ioMemN(ctl.ioMemN),
    .keyReturn(keyReturn), .adOut(adOut), .adOe(adOe), .addrOut(addrOut),
    .romStdN(romStdN), .romOptN(romOptN), .ramSelN(ramSelN),
    .io_sel_ext_unit_n(sel[0]), .io_sel_line_relay_n(sel[1]),
    .io_sel_parallel_ctrl_n(sel[2]), .io_sel_serial_data_n(sel[3]),
    .io_sel_serial_mode_n(sel[4]), .io_sel_output_latch_n(sel[5]),
    .io_sel_display_n(sel[6]), .rom_bank_select(lat[0]), .printer_data_strobe(lat[1]),
    .clock_chip_strobe(lat[2]), .cassetteMotor(lat[3]));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    chk("reset", {lat, sel, adOe}, {4'h0, 7'h7F, 1'b0});
    rst <= 1'b0;
    cpu.access(1'b0, 1'b0, 16'h1234, 8'h00);
    chk("rom std", {romStdN, romOptN, ramSelN}, 6'h1F);
    chk("addr", addrOut, 16'h1234);
    cpu.idle();
    for (int i = 0; i < 4; i++) begin
      cpu.access(1'b0, 1'b1, {1'b1, i[1:0], 13'h1FFF}, 8'h00);
      chk("ram", {romStdN, romOptN, ramSelN}, {2'h3, ~(4'h1 << i)});
      cpu.idle();
    end
    for (int n = 0; n < 16; n++) begin
      k = (n < 8 || n == 10) ? 7 : (n < 10 ? n - 8 : n - 9);
      cpu.access(1'b1, 1'b0, {n[3:0], 12'h5C3}, 8'h00);
      chk("io", sel, 8'h7F & ~(8'h1 << k));
      chk("io mem", {romStdN, ramSelN}, 5'h1F);
      if (n == 14) chk("key", {adOe, adOut}, {1'b1, keyReturn});
      cpu.idle();
    end
    cpu.access(1'b1, 1'b1, 16'hE0E0, 8'hFB);
    chk("latch", lat, 4'hB);
    cpu.idle();
    cpu.access(1'b0, 1'b0, 16'h7FFF, 8'h00);
    chk("rom opt", {romStdN, romOptN}, 2'h2);
    cpu.idle();
    cpu.access(1'b1, 1'b1, 16'hD000, 8'h04);
    cpu.idle();
    cpu.access(1'b0, 1'b1, 16'hE000, 8'h04);
    chk("hold", lat, 4'hB);
    cpu.idle();
    cpu.access(1'b1, 1'b1, 16'hEF00, 8'h04);
    chk("latch 2", lat, 4'h4);
    cpu.idle();
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("rst mid", {lat, sel}, {4'h0, 7'h7F});
    close_out();
  end
endmodule : tb
